// ===== logic/hw_limit_switch_monitor.sv
/*
 End-of-travel switch monitor: evaluates two switch inputs, orders a
 quick stop, latches a class 1 error and blocks motion toward a tripped
 switch. Assumes a simple 16-bit parameter write/read port and
 direction request strobes from the motion core.
*/
`timescale 1ns/100ps
module hw_limit_switch_monitor
	import limit_switch_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        positive_end_switch_input,
	input  wire logic        negative_end_switch_input,
	input  wire logic        pos_input_assigned,
	input  wire logic        neg_input_assigned,
	input  wire logic        power_stage_enabled,
	input  wire logic        fault_reset,
	input  wire logic        move_pos_req,
	input  wire logic        move_neg_req,
	input  wire logic        par_wr,
	input  wire logic        par_rd,
	input  wire logic [15:0] par_addr,
	input  wire logic [15:0] par_wdata,
	output logic      [15:0] par_rdata,
	output logic             par_ack,
	output logic             quick_stop,
	output logic      [15:0] quick_stop_reaction_out,
	output logic             error_flag,
	output logic      [3:0]  error_class,
	output logic             move_pos_allow,
	output logic             move_neg_allow
);
	// ****************************************************
	// Input synchronisers
	// ****************************************************
	logic pos_sync;
	logic neg_sync;

	switch_sync u_pos_sync
	(
		.clock    (clock),
		.rst      (rst),
		.raw_in   (positive_end_switch_input),
		.sync_out (pos_sync)
	);

	switch_sync u_neg_sync
	(
		.clock    (clock),
		.rst      (rst),
		.raw_in   (negative_end_switch_input),
		.sync_out (neg_sync)
	);

	// ****************************************************
	// Parameter registers
	// ****************************************************
	logic [15:0] positive_switch_eval_r;
	logic [15:0] negative_switch_eval_r;
	logic [15:0] switch_temp_mask_r;
	logic [15:0] quick_stop_reaction_r;
	logic [1:0]  pos_eval_act_r;
	logic [1:0]  neg_eval_act_r;
	logic        power_prev_r;
	logic        pos_trip_r;
	logic        neg_trip_r;
	logic        pos_block_r;
	logic        neg_block_r;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			positive_switch_eval_r <= EVAL_RESET;
			negative_switch_eval_r <= EVAL_RESET;
			switch_temp_mask_r     <= MASK_RESET;
			quick_stop_reaction_r  <= QSTOP_RESET;
		end
		else if (par_wr)
		begin
			if (par_addr == POS_EVAL_ADDR && !power_stage_enabled)
				positive_switch_eval_r <= par_wdata;
			if (par_addr == NEG_EVAL_ADDR && !power_stage_enabled)
				negative_switch_eval_r <= par_wdata;
			if (par_addr == TEMP_MASK_ADDR)
				switch_temp_mask_r <= par_wdata;
			if (par_addr == QSTOP_REACT_ADDR)
				quick_stop_reaction_r <= par_wdata;
		end
	end

	// Active evaluation copies load on power stage enable
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			power_prev_r   <= 1'b0;
			pos_eval_act_r <= EVAL_NC;
			neg_eval_act_r <= EVAL_NC;
		end
		else
		begin
			power_prev_r <= power_stage_enabled;
			if (power_stage_enabled && !power_prev_r)
			begin
				pos_eval_act_r <= positive_switch_eval_r[1:0];
				neg_eval_act_r <= negative_switch_eval_r[1:0];
			end
		end
	end

	// ****************************************************
	// Switch evaluation
	// ****************************************************
	function automatic logic tripped(input logic [1:0] ev, input logic lvl);
		tripped = (ev == EVAL_NC) ? !lvl : (ev == EVAL_NO) ? lvl : 1'b0;
	endfunction

	logic pos_trip_now;
	logic neg_trip_now;
	logic pos_event;
	logic neg_event;
	logic toward_pos;
	logic toward_neg;

	always_comb
	begin
		pos_trip_now = pos_input_assigned
			&& tripped(pos_eval_act_r, pos_sync);
		neg_trip_now = neg_input_assigned
			&& tripped(neg_eval_act_r, neg_sync);
		pos_event = pos_trip_now
			&& !switch_temp_mask_r[MASK_POS_BIT];
		neg_event = neg_trip_now
			&& !switch_temp_mask_r[MASK_NEG_BIT];
		toward_pos = move_pos_req && pos_block_r;
		toward_neg = move_neg_req && neg_block_r;
	end

	// ****************************************************
	// Trip status registers, block and error latches
	// ****************************************************
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pos_trip_r  <= 1'b0;
			neg_trip_r  <= 1'b0;
			pos_block_r <= 1'b0;
			neg_block_r <= 1'b0;
			error_flag  <= 1'b0;
			error_class <= 4'h0;
		end
		else
		begin
			pos_trip_r <= pos_event;
			neg_trip_r <= neg_event;
			if (pos_event || neg_event || toward_pos || toward_neg)
			begin
				error_flag  <= 1'b1;
				error_class <= ERROR_CLASS_ONE;
			end
			else if (fault_reset)
			begin
				error_flag  <= 1'b0;
				error_class <= 4'h0;
			end
			// Block stays until fault_reset, also after the switch releases
			pos_block_r <= pos_event || (pos_block_r && !fault_reset);
			neg_block_r <= neg_event || (neg_block_r && !fault_reset);
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			quick_stop              <= 1'b0;
			quick_stop_reaction_out <= QSTOP_RESET;
			move_pos_allow          <= 1'b1;
			move_neg_allow          <= 1'b1;
		end
		else
		begin
			quick_stop <= pos_event || neg_event
				|| toward_pos || toward_neg;
			quick_stop_reaction_out <= quick_stop_reaction_r;
			move_pos_allow <= !(pos_event
				|| (pos_block_r && !fault_reset));
			move_neg_allow <= !(neg_event
				|| (neg_block_r && !fault_reset));
		end
	end

	// Read port
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			par_rdata <= 16'h0000;
			par_ack   <= 1'b0;
		end
		else
		begin
			par_ack <= par_rd || par_wr;
			par_rdata <= 16'h0000;
			if (par_rd)
			begin
				unique case (par_addr)
					POS_EVAL_ADDR:    par_rdata <= positive_switch_eval_r;
					NEG_EVAL_ADDR:    par_rdata <= negative_switch_eval_r;
					TEMP_MASK_ADDR:   par_rdata <= switch_temp_mask_r;
					QSTOP_REACT_ADDR: par_rdata <= quick_stop_reaction_r;
					STATUS_ADDR:
					begin
						par_rdata[ST_POS_TRIP]  <= pos_trip_r;
						par_rdata[ST_NEG_TRIP]  <= neg_trip_r;
						par_rdata[ST_ERROR]     <= error_flag;
						par_rdata[ST_QSTOP]     <= quick_stop;
						par_rdata[ST_POS_BLOCK] <= pos_block_r;
						par_rdata[ST_NEG_BLOCK] <= neg_block_r;
					end
					default:          par_rdata <= 16'h0000;
				endcase
			end
		end
	end
endmodule

// ===== logic/limit_switch_pkg.sv
/*
 Constants for the end-of-travel switch monitor: parameter addresses,
 reset values, evaluation codes and mask codes.
 Assumes a 16-bit parameter port addressed by even byte address, two per word.
*/
package limit_switch_pkg;
	// ****************************************************
	// Parameter addresses
	// ****************************************************
	localparam logic [15:0] NEG_EVAL_ADDR   = 16'h061E;
	localparam logic [15:0] POS_EVAL_ADDR   = 16'h0620;
	localparam logic [15:0] TEMP_MASK_ADDR  = 16'h064A;
	localparam logic [15:0] QSTOP_REACT_ADDR = 16'h064C;
	localparam logic [15:0] STATUS_ADDR     = 16'h064E;
	// ****************************************************
	// Reset values and codes
	// ****************************************************
	localparam logic [15:0] EVAL_RESET      = 16'h0001;
	localparam logic [15:0] MASK_RESET      = 16'h0000;
	localparam logic [15:0] QSTOP_RESET     = 16'h0000;
	localparam logic [1:0]  EVAL_OFF        = 2'h0;
	localparam logic [1:0]  EVAL_NC         = 2'h1;
	localparam logic [1:0]  EVAL_NO         = 2'h2;
	localparam int          MASK_POS_BIT    = 0;
	localparam int          MASK_NEG_BIT    = 1;
	localparam logic [3:0]  ERROR_CLASS_ONE = 4'h1;
	// Status word bit positions
	localparam int ST_POS_TRIP  = 0;
	localparam int ST_NEG_TRIP  = 1;
	localparam int ST_ERROR     = 2;
	localparam int ST_QSTOP     = 3;
	localparam int ST_POS_BLOCK = 4;
	localparam int ST_NEG_BLOCK = 5;
endpackage

// ===== logic/switch_sync.sv
/*
 Two-stage synchroniser for one asynchronous switch input.
 Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module switch_sync
(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic raw_in,
	output logic      sync_out
);
	logic meta_r;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			// Closed-contact idle level, no false trip after reset
			meta_r   <= 1'b1;
			sync_out <= 1'b1;
		end
		else
		begin
			meta_r   <= raw_in;
			sync_out <= meta_r;
		end
	end
endmodule

// ===== testbench/limit_checker.sv
/*
 Port checker for the switch monitor.
 Assumes it is bound into the monitor by name.
*/
`timescale 1ns/100ps
module limit_checker
(
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       fault_reset,
	input wire logic       move_pos_req,
	input wire logic       move_neg_req,
	input wire logic       quick_stop,
	input wire logic       error_flag,
	input wire logic [3:0] error_class,
	input wire logic       move_pos_allow,
	input wire logic       move_neg_allow
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_class_value: assert property (
		error_class == (error_flag ? 4'h1 : 4'h0))
		else $error("error class wrong");
	a_error_hold: assert property (
		error_flag && !fault_reset |=> error_flag)
		else $error("error dropped");
	a_stop_error: assert property (
		quick_stop |-> error_flag)
		else $error("stop without error");
	a_rise_stop: assert property (
		$rose(error_flag) |-> quick_stop)
		else $error("error without stop");
	a_block_error: assert property (
		$fell(move_pos_allow) || $fell(move_neg_allow) |-> error_flag)
		else $error("block without error");
	a_pos_block: assert property (
		!move_pos_allow && !fault_reset |=> !move_pos_allow)
		else $error("positive block dropped");
	a_neg_block: assert property (
		!move_neg_allow && !fault_reset |=> !move_neg_allow)
		else $error("negative block dropped");
	a_pos_forbid: assert property (
		move_pos_req && !move_pos_allow && !fault_reset |-> ##[0:1] quick_stop)
		else $error("positive move not stopped");
	a_neg_forbid: assert property (
		move_neg_req && !move_neg_allow && !fault_reset |-> ##[0:1] quick_stop)
		else $error("negative move not stopped");
endmodule

bind hw_limit_switch_monitor limit_checker u_limit_checker (.*);

// ===== testbench/end_switch_pair.sv
/*
 Two end-of-travel switches on the axis.
 Assumes the bench sets which are hit and the contact kind.
*/
`timescale 1ns/100ps
module end_switch_pair
(
	input  wire logic pos_hit,
	input  wire logic neg_hit,
	input  wire logic contact_no,
	output logic      pos_pin,
	output logic      neg_pin
);
	// Closed contact opens when hit, open contact closes
	assign pos_pin = pos_hit ~^ contact_no;
	assign neg_pin = neg_hit ~^ contact_no;
endmodule

// ===== testbench/hw_limit_switch_monitor_tb.sv
/*
 Self-checking bench for the switch monitor.
 Assumes the package, the design, the switch model and the checker.
*/
`timescale 1ns/100ps
module hw_limit_switch_monitor_tb;
	import limit_switch_pkg::*;
	typedef struct {logic [15:0] a; logic [15:0] d; logic [15:0] q;} row_s;
	logic        clock = 1'b0, rst = 1'b1, fault_reset = 1'b0;
	logic        pos_input_assigned = 1'b1, neg_input_assigned = 1'b1;
	logic        power_stage_enabled = 1'b0, par_wr = 1'b0, par_rd = 1'b0;
	logic        move_pos_req = 1'b0, move_neg_req = 1'b0;
	logic        pos_hit = 1'b0, neg_hit = 1'b0, contact_no = 1'b0;
	logic [15:0] par_addr = 16'h0000, par_wdata = 16'h0000;
	logic [15:0] par_rdata, quick_stop_reaction_out;
	logic        par_ack, quick_stop, error_flag;
	logic        move_pos_allow, move_neg_allow;
	logic [3:0]  error_class;
	logic        positive_end_switch_input, negative_end_switch_input;
	int          errors = 0, n_compared = 0, cycles = 0;
	row_s        rows [6] = '{'{POS_EVAL_ADDR, 16'h0002, 16'h0002},
		'{NEG_EVAL_ADDR, 16'h0002, 16'h0002},
		'{TEMP_MASK_ADDR, 16'h0003, 16'h0003},
		'{TEMP_MASK_ADDR, 16'h0000, 16'h0000},
		'{QSTOP_REACT_ADDR, 16'h0002, 16'h0002},
		'{16'h0700, 16'h00AA, 16'h0000}};

	hw_limit_switch_monitor u_hw_limit_switch_monitor (.*);
	end_switch_pair u_end_switch_pair
	(
		.pos_hit    (pos_hit),
		.neg_hit    (neg_hit),
		.contact_no (contact_no),
		.pos_pin    (positive_end_switch_input),
		.neg_pin    (negative_end_switch_input)
	);

	always #5 clock = ~clock;

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			errors++;
			summarize();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		par_addr = a;
		par_wdata = d;
		par_wr = 1'b1;
		@(negedge clock);
		par_wr = 1'b0;
		@(negedge clock);
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		par_addr = a;
		par_rd = 1'b1;
		@(negedge clock);
		par_rd = 1'b0;
		chk(par_rdata, exp);
		chk(par_ack, 1'b1);
		@(negedge clock);
	endtask

	task automatic clear_fault();
		fault_reset = 1'b1;
		@(negedge clock);
		fault_reset = 1'b0;
		@(negedge clock);
	endtask

	initial
	begin
		repeat (20) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		rd(POS_EVAL_ADDR, EVAL_RESET);
		rd(NEG_EVAL_ADDR, EVAL_RESET);
		rd(TEMP_MASK_ADDR, MASK_RESET);
		chk(error_flag, 1'b0);
		chk(move_pos_allow, 1'b1);
		$display("reset test done");
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].q);
		end
		chk(quick_stop_reaction_out, 16'h0002);
		repeat (4) @(negedge clock);
		chk(error_flag, 1'b0);
		power_stage_enabled = 1'b1;
		contact_no = 1'b1;
		// Wiring and setting change together: clear that trip
		repeat (4) @(negedge clock);
		clear_fault();
		wr(POS_EVAL_ADDR, 16'h0000);
		rd(POS_EVAL_ADDR, 16'h0002);
		chk(error_flag, 1'b0);
		$display("config test done");
		for (int m = 0; m < 4; m++)
		begin
			wr(TEMP_MASK_ADDR, 16'(m));
			{pos_hit, neg_hit} = 2'b11;
			repeat (4) @(negedge clock);
			chk(error_flag, m != 3);
			chk(quick_stop, m != 3);
			chk(error_class, m != 3);
			chk(move_pos_allow, m[0]);
			chk(move_neg_allow, m[1]);
			{pos_hit, neg_hit} = 2'b00;
			repeat (4) @(negedge clock);
			chk(error_flag, m != 3);
			clear_fault();
			chk(error_flag, 1'b0);
		end
		$display("mask test done");
		wr(TEMP_MASK_ADDR, 16'h0000);
		pos_hit = 1'b1;
		repeat (4) @(negedge clock);
		rd(STATUS_ADDR, 16'((1 << ST_POS_TRIP) | (1 << ST_ERROR)
			| (1 << ST_QSTOP) | (1 << ST_POS_BLOCK)));
		pos_hit = 1'b0;
		repeat (4) @(negedge clock);
		move_pos_req = 1'b1;
		@(negedge clock);
		chk(quick_stop, 1'b1);
		move_pos_req = 1'b0;
		move_neg_req = 1'b1;
		repeat (2) @(negedge clock);
		chk(quick_stop, 1'b0);
		chk(move_neg_allow, 1'b1);
		move_neg_req = 1'b0;
		clear_fault();
		$display("direction test done");
		power_stage_enabled = 1'b0;
		wr(NEG_EVAL_ADDR, 16'h0000);
		power_stage_enabled = 1'b1;
		neg_hit = 1'b1;
		pos_input_assigned = 1'b0;
		pos_hit = 1'b1;
		repeat (4) @(negedge clock);
		chk(error_flag, 1'b0);
		chk(move_neg_allow, 1'b1);
		chk(move_pos_allow, 1'b1);
		$display("inactive test done");
		pos_input_assigned = 1'b1;
		{pos_hit, neg_hit} = 2'b00;
		contact_no = 1'b0;
		rst = 1'b1;
		repeat (3) @(negedge clock);
		rst = 1'b0;
		repeat (3) @(negedge clock);
		chk(error_flag, 1'b0);
		chk(move_pos_allow, 1'b1);
		rd(NEG_EVAL_ADDR, EVAL_RESET);
		$display("mid reset test done");
		summarize();
	end
endmodule
